// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, err, evGo;
  logic configMode, isCurrentMaster, inSchedule, cycleStartPulse, triggerMarkPulse;
  logic basicStart, matrixStart, trigActive, refMsgSeen, ntuTick, localTimeRun;
  logic txCountOverFlag, txCountUnderFlag, globalTimeErrorFlag, masterActive, gapMode;
  logic [1:0] evSel, operationModeSelect;
  logic [11:0] paddr, txTrigCount;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] syncDeviation;
  logic [17:0] actualNumerator;
  logic [13:0] unitDenominator;
  logic [4:0] txWindowLength;
  logic [6:0] basicCyclesPerMatrix;
  logic markIrq, extEvent, extSyncWait, wdServe, refStartReq, phaseAlign, watchdogExpired;
  int errors, cmp_count, cyc, csCnt, tmCnt, ovCnt, unCnt, rqCnt, paCnt;
  ttc_timebase_config #(.SYNC_STAGES(8)) i_ttc_timebase_config (.ref_clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .configMode,
    .isCurrentMaster, .extSyncWait, .refMsgSeen, .markIrq, .trigActive,
    .inSchedule, .basicStart, .matrixStart, .ntuTick, .txTrigCount, .syncDeviation,
    .extEvent, .cycleStartPulse, .triggerMarkPulse, .refStartReq, .phaseAlign,
    .watchdogExpired, .txCountOverFlag, .txCountUnderFlag, .globalTimeErrorFlag,
    .actualNumerator, .unitDenominator, .localTimeRun, .masterActive, .gapMode,
    .operationModeSelect, .txWindowLength, .basicCyclesPerMatrix, .wdServe);
  ttc_bus_model i_ttc_bus_model (.ref_clk, .rst, .evSel, .evGo, .basicStart, .matrixStart,
    .trigActive, .refMsgSeen, .ntuTick);
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  // pulse counters and hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cycleStartPulse === 1'b1) csCnt++;
    if (triggerMarkPulse === 1'b1) tmCnt++;
    if (txCountOverFlag === 1'b1) ovCnt++;
    if (txCountUnderFlag === 1'b1) unCnt++;
    if (refStartReq === 1'b1) rqCnt++;
    if (phaseAlign === 1'b1) paCnt++;
    if (cyc == 20000) begin
      errors++;
      test_done;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // apb master and event request
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic ev(input logic [1:0] s);
    evSel <= s;
    evGo <= 1'b1;
    @(posedge ref_clk);
    evGo <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    apb(0, 12'h108, 0);
    chk("ocf", 32'h00010000, rd);
    chk("num", 32'h10000, 32'(actualNumerator));
    chk("den", 32'h1000, 32'(unitDenominator));
    chk("mode", 0, 32'(operationModeSelect));
    apb(0, 12'h200, 0);
    chk("slverr", 1, 32'(err));
  endtask
  task automatic t_protect;
    apb(1, 12'h10c, 32'h01230f3f);
    apb(0, 12'h10c, 0);
    chk("mlm_locked", 0, rd);
    configMode <= 1'b1;
    apb(1, 12'h10c, 32'h01230f3f);
    apb(0, 12'h10c, 0);
    chk("mlm", 32'h01230f3f, rd);
    chk("window", 16, 32'(txWindowLength));
    chk("matrix", 64, 32'(basicCyclesPerMatrix));
  endtask
  task automatic t_cstart;
    for (int c = 0; c < 3; c++) begin
      apb(1, 12'h10c, 32'(c << 6));
      csCnt = 0;
      ev(1);
      chk("sync_basic", 32'(c == 1), 32'(csCnt));
      ev(2);
      chk("sync_all", 32'(c != 0), 32'(csCnt));
    end
  endtask
  task automatic t_txcnt;
    apb(1, 12'h10c, 32'h00030000);
    for (int k = 2; k < 5; k++) begin
      txTrigCount <= 12'(k);
      ovCnt = 0;
      unCnt = 0;
      ev(2);
      chk("tx_over", 32'(k > 3), 32'(ovCnt));
      chk("tx_under", 32'(k < 3), 32'(unCnt));
    end
  endtask
  task automatic t_tur;
    apb(1, 12'h110, 32'h08001234);
    chk("num_set", 32'h11234, 32'(actualNumerator));
    apb(1, 12'h110, 32'h00001234);
    chk("den_zero", 32'h0800, 32'(unitDenominator));
    apb(1, 12'h110, 32'h88001234);
    repeat (12) @(posedge ref_clk);
    chk("run", 1, 32'(localTimeRun));
    apb(1, 12'h110, 32'h84001234);
    chk("den_lock", 32'h0800, 32'(unitDenominator));
    apb(1, 12'h110, 32'h08001234);
    apb(0, 12'h110, 0);
    chk("elt_hold", 1, 32'(rd[31]));
    repeat (20) @(posedge ref_clk);
    apb(0, 12'h110, 0);
    chk("elt_off", 0, 32'(rd[31]));
    chk("stop", 0, 32'(localTimeRun));
  endtask
  task automatic t_lock;
    apb(1, 12'h114, 32'h100);
    apb(1, 12'h114, 32'h0);
    apb(0, 12'h114, 0);
    chk("ocn_lock", 32'h8100, rd);
    repeat (20) @(posedge ref_clk);
    apb(0, 12'h114, 0);
    chk("ocn", 32'h0100, rd);
    tmCnt = 0;
    ev(3);
    chk("mark_off", 0, 32'(tmCnt));
    inSchedule <= 1'b1;
    ev(3);
    chk("mark_on", 1, 32'(tmCnt));
  endtask
  task automatic t_modes;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      apb(1, 12'h108, {16'h0001, 11'h0, m[0], m[1], 1'b0, m});
      chk("mode", 32'(m), 32'(operationModeSelect));
      chk("master", 32'(m[0]), 32'(masterActive));
      chk("gap", 32'(m[1]), 32'(gapMode));
    end
  endtask
  task automatic t_gte;
    int lim;
    for (int l = 0; l < 8; l++) begin
      lim = 1 << (l + 5);
      apb(1, 12'h108, 32'h00010002 | 32'(l << 5));
      syncDeviation <= 16'(lim);
      repeat (4) @(posedge ref_clk);
      chk("gte_at", 0, 32'(globalTimeErrorFlag));
      syncDeviation <= 16'(lim + 1);
      repeat (4) @(posedge ref_clk);
      chk("gte_over", 1, 32'(globalTimeErrorFlag));
    end
    apb(1, 12'h108, 32'h00010001);
    chk("gte_lvl1", 0, 32'(globalTimeErrorFlag));
  endtask
  task automatic t_gap;
    apb(1, 12'h114, 32'h400);
    chk("fgp_req", 1, 32'(refStartReq));
    ev(1);
    chk("fgp_clr", 0, 32'(refStartReq));
    apb(1, 12'h114, 32'h1800);
    apb(0, 12'h114, 0);
    chk("nig_slave", 32'h0800, 32'(rd[13:0]));
    rqCnt = 0;
    markIrq <= 1'b1;
    @(posedge ref_clk);
    markIrq <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("tmg_req", 1, 32'(rqCnt));
    ev(2);
    apb(1, 12'h108, 32'h00010008);
    isCurrentMaster <= 1'b1;
    apb(1, 12'h114, 32'h1000);
    apb(0, 12'h114, 0);
    chk("nig_master", 32'h1000, 32'(rd[13:0]));
    ev(2);
    apb(0, 12'h114, 0);
    chk("nig_clr", 0, 32'(rd[13:0]));
  endtask
  task automatic t_ext;
    apb(1, 12'h114, 32'h2000);
    paCnt = 0;
    extEvent <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("phase_align", 1, 32'(paCnt));
    extEvent <= 1'b0;
    apb(1, 12'h108, 32'h00018000);
    configMode <= 1'b0;
    apb(1, 12'h110, 32'h08005555);
    chk("ncl_defer", 32'h11234, 32'(actualNumerator));
    extSyncWait <= 1'b1;
    apb(1, 12'h110, 32'h08006666);
    extSyncWait <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("ncl_land", 32'h15555, 32'(actualNumerator));
    configMode <= 1'b1;
  endtask
  task automatic t_wdog;
    apb(1, 12'h110, 32'h88005555);
    repeat (1200) @(posedge ref_clk);
    apb(0, 12'h130, 0);
    chk("wd_count", 32'h01000001, rd);
    repeat (1000) @(posedge ref_clk);
    chk("wd_expired", 1, 32'(watchdogExpired));
    wdServe <= 1'b1;
    @(posedge ref_clk);
    wdServe <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("wd_served", 0, 32'(watchdogExpired));
  endtask
  initial begin
    {rst, psel, penable, pwrite, evGo, configMode, isCurrentMaster, inSchedule} = 8'h80;
    {paddr, pwdata, evSel, txTrigCount, syncDeviation} = '0;
    {markIrq, extEvent, extSyncWait, wdServe} = 4'h0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_protect;
    t_cstart;
    t_txcnt;
    t_tur;
    t_lock;
    t_modes;
    t_gte;
    t_gap;
    t_ext;
    t_wdog;
    test_done;
  end
endmodule // tb
`default_nettype wire

// File: sim/ttc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// other nodes: cycle starts, triggers, ticks
// ****************************************
module ttc_bus_model (
  input wire logic ref_clk, // clock
  input wire logic rst, // sync reset
  input wire logic [1:0] evSel, // 1 basic, 2 matrix, 3 trigger
  input wire logic evGo, // one event request
  output logic basicStart, // basic cycle start pulse
  output logic matrixStart, // matrix cycle start pulse
  output logic trigActive, // trigger element active
  output logic refMsgSeen, // reference message seen
  output logic ntuTick // time unit tick
);
  logic [1:0] tickCnt_q; // tick divider
  // each cycle start comes with a reference message
  always @(posedge ref_clk) begin
    tickCnt_q <= rst ? 2'h0 : tickCnt_q + 2'h1;
    ntuTick <= !rst && tickCnt_q == 2'h0;
    basicStart <= evGo && evSel == 2'h1;
    matrixStart <= evGo && evSel == 2'h2;
    refMsgSeen <= evGo && evSel[1] != evSel[0];
    trigActive <= evGo && evSel == 2'h3;
  end
endmodule // ttc_bus_model
`default_nettype wire

// File: sim/ttc_timebase_config_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker for the timebase config
// ****************************************
module ttc_timebase_config_sva (
  input wire logic ref_clk, // clock
  input wire logic rst, // sync reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic inSchedule, // schedule state
  input wire logic trigActive, // trigger active
  input wire logic basicStart, // basic cycle start
  input wire logic matrixStart, // matrix cycle start
  input wire logic cycleStartPulse, // sync pulse out
  input wire logic triggerMarkPulse, // mark pulse out
  input wire logic txCountOverFlag, // over flag
  input wire logic txCountUnderFlag, // under flag
  input wire logic globalTimeErrorFlag, // deviation flag
  input wire logic [15:0] syncDeviation, // deviation in
  input wire logic [17:0] actualNumerator, // numerator
  input wire logic [13:0] unitDenominator, // denominator
  input wire logic localTimeRun, // local time on
  input wire logic [4:0] txWindowLength, // window
  input wire logic [6:0] basicCyclesPerMatrix // matrix length
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ready is a single pulse, one wait state after access
  a_ready_once: assert property (pready |=> !pready) else $error("ready held");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("lone error");
  a_numer_top: assert property (actualNumerator[17:16] == 2'b01)
    else $error("numerator top bits");
  a_denom_legal: assert property (unitDenominator != 14'h0)
    else $error("denominator zero");
  a_denom_hold: assert property (localTimeRun && $past(localTimeRun)
    |-> $stable(unitDenominator)) else $error("denominator moved");
  a_window_range: assert property (txWindowLength inside {[5'd1:5'd16]})
    else $error("window range");
  a_matrix_range: assert property (basicCyclesPerMatrix inside {[7'd1:7'd64]})
    else $error("matrix range");
  a_start_cause: assert property (cycleStartPulse |-> $past(basicStart) ||
    $past(matrixStart) || $past(basicStart, 2) || $past(matrixStart, 2))
    else $error("sync pulse uncaused");
  a_mark_cause: assert property (triggerMarkPulse |->
    ($past(trigActive) && $past(inSchedule)) || ($past(trigActive, 2) && $past(inSchedule, 2)))
    else $error("mark pulse uncaused");
  a_flags_apart: assert property (!(txCountOverFlag && txCountUnderFlag))
    else $error("over and under");
  a_gte_cause: assert property (globalTimeErrorFlag |->
    $past(syncDeviation) > 16'd32 || $past(syncDeviation, 2) > 16'd32)
    else $error("deviation flag uncaused");
  c_sync: cover property (cycleStartPulse);
  c_mark: cover property (triggerMarkPulse);
  c_gte: cover property (globalTimeErrorFlag);
  c_err: cover property (pslverr);
endmodule // ttc_timebase_config_sva
bind ttc_timebase_config ttc_timebase_config_sva i_sva (.ref_clk, .rst, .psel, .penable,
  .pready, .pslverr, .inSchedule, .trigActive, .basicStart, .matrixStart, .cycleStartPulse,
  .triggerMarkPulse, .txCountOverFlag, .txCountUnderFlag, .globalTimeErrorFlag,
  .syncDeviation, .actualNumerator, .unitDenominator, .localTimeRun, .txWindowLength,
  .basicCyclesPerMatrix);
`default_nettype wire

// File: src/ttc_consts.vh
`ifndef TTC_CONSTS_VH
`define TTC_CONSTS_VH
// register byte addresses
`define TTC_ADDR_OCF 12'h108
`define TTC_ADDR_MLM 12'h10c
`define TTC_ADDR_TUR 12'h110
`define TTC_ADDR_OCN 12'h114
`define TTC_ADDR_STS 12'h130
// reset values
`define TTC_OCF_RST 32'h00010000
`define TTC_MLM_RST 32'h00000000
`define TTC_DEN_RST 14'h1000
`define TTC_NCL_RST 16'h0000
`define TTC_NCH_VAL 2'h1
// field positions
`define TTC_AWL_LSB 16
`define TTC_EXT_CLOCK_SYNC_ENABLE_BIT 15
`define TTC_SYNC_DEV_LIMIT_LOG_LSB 5
`define TTC_TM_BIT 4
`define TTC_GEN_BIT 3
`define TTC_ELT_BIT 31
`define TTC_DEN_LSB 16
`define TTC_OP_CONTROL_LOCK_BIT 15
// operation modes
`define TTC_OM_EVENT 2'h0
`define TTC_OM_LVL1 2'h1
`define TTC_OM_LVL2 2'h2
`define TTC_OM_LVL0 2'h3
// timing
`define TTC_WD_NTU 256
`define TTC_SDL_BASE 5
`endif

// File: src/ttc_timebase_config.v
// Function
// - watchdog ticks every 256 NTU; zero limit disables
// - numerator low writable when stopped or ext sync
// - deviation limit is two to log plus five
// - master enable bit gates time master function
// - gap enable selects event-synchronized operation
// - mode field selects event, level 1, 2, 0
// - twelve bit expected transmit trigger count
// - transmit window is field plus one
// - cycle start pulse select none basic matrix
// - basic cycles per matrix is field plus one
// - NTU from numerator over denominator, numerator 01 top
// - denominator resets 0x1000, never written zero
// - local time runs while enabled; denominator locked
// - enable readback stays one until crossed; lock
// - numerator low held while sync wait flag set
// - control write sets lock until crossed
// - external event rising edges align cycle phase
// - next gap settable only as master with gap
// - mark gap starts reference on mark irq; cleared
// - finish gap request cleared by reference message
// - trigger mark pulse only in schedule or gap
// - flag transmit count over and under
// - global time error when deviation exceeds limit, levels 0 and 2 only
`timescale 1ns/1ps
`default_nettype none
`include "ttc_consts.vh"
module ttc_timebase_config #(
  parameter SYNC_STAGES = 2 // crossing handshake delay, cycles
) (
  input wire ref_clk, // clock, 250 MHz
  input wire rst, // synchronous reset, high
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error
  input wire configMode, // controller in configuration state
  input wire isCurrentMaster, // node is current time master
  input wire extSyncWait, // external clock sync wait flag
  input wire refMsgSeen, // reference message received or sent
  input wire markIrq, // register time mark event
  input wire trigActive, // trigger memory element active
  input wire inSchedule, // sync state in schedule or in gap
  input wire basicStart, // start of basic cycle
  input wire matrixStart, // start of matrix cycle
  input wire ntuTick, // one network time unit elapsed
  input wire [11:0] txTrigCount, // transmit triggers this matrix cycle
  input wire [15:0] syncDeviation, // magnitude of sync deviation
  input wire extEvent, // external event pin
  output reg cycleStartPulse, // cycle start sync pulse
  output reg triggerMarkPulse, // trigger time mark pulse
  output reg refStartReq, // start reference message request
  output reg phaseAlign, // align cycle phase to external event
  output reg watchdogExpired, // application watchdog not served
  output reg txCountOverFlag, // more triggers than expected
  output reg txCountUnderFlag, // fewer triggers than expected
  output reg globalTimeErrorFlag, // deviation above limit
  output reg [17:0] actualNumerator, // actual numerator in use
  output reg [13:0] unitDenominator, // denominator in use
  output reg localTimeRun, // local time running
  output reg masterActive, // time master function enabled
  output reg gapMode, // event-synchronized operation
  output reg [1:0] operationModeSelect, // operation mode
  output reg [4:0] txWindowLength, // window length in NTU
  output reg [6:0] basicCyclesPerMatrix, // matrix length
  input wire wdServe // application serves watchdog
);
  // ****************************************
  // register state
  // ****************************************
  reg [31:0] opConfig_q; // operation configuration word
  reg [27:0] matrixLimits_q; // matrix limits fields
  reg [15:0] numLow_q; // configured numerator low
  reg [15:0] numLowPend_q; // numerator low waiting for flag
  reg numPend_q; // a pending numerator update exists
  reg [13:0] den_q; // configured denominator
  reg elt_q; // enable written by host
  reg eltSync_q; // enable as seen by time base
  reg [SYNC_STAGES-1:0] eltPipe_q; // crossing pipe for enable
  reg [13:0] opControl_q; // operation control bits 13:0
  reg lock_q; // control register lock
  reg [SYNC_STAGES-1:0] lockPipe_q; // crossing pipe for lock
  reg [15:0] wdPre_q; // NTU prescaler for watchdog
  reg [7:0] wdCnt_q; // watchdog count
  reg [2:0] evtS_q; // event pin synchroniser
  reg evtLvl_q; // filtered event level
  reg extWaitPrev_q; // previous wait flag
  wire acc = psel && penable; // access phase
  wire wr = acc && pwrite; // write strobe
  wire [12:0] sync_deviation_limit; // deviation limit
  wire [7:0] app_watchdog_limit = opConfig_q[`TTC_AWL_LSB+7:`TTC_AWL_LSB]; // watchdog limit
  wire ext_clock_sync_enable = opConfig_q[`TTC_EXT_CLOCK_SYNC_ENABLE_BIT]; // ext clock sync enable
  // while the enable crosses, the whole ratio register refuses writes
  wire eltBusy = elt_q != eltSync_q; // enable still crossing
  // level starts low like the idle pin, so reset makes no false edge
  wire evtRise = evtS_q[2] == evtS_q[1] && evtS_q[1] && !evtLvl_q; // settled rise
  // expiry: limit reached as another 256-unit period completes
  wire wdExpire = ntuTick && localTimeRun && wdPre_q == `TTC_WD_NTU - 1 && wdCnt_q == app_watchdog_limit;
  // deviation limit decode
  // the shift amount reaches twelve, so the log is widened before the
  // offset is added; a three-bit sum would wrap past seven
  function [12:0] sdlOf;
    input [2:0] ld;
    begin
      sdlOf = 13'h0001 << ({1'b0, ld} + `TTC_SDL_BASE);
    end
  endfunction
  assign sync_deviation_limit = sdlOf(opConfig_q[`TTC_SYNC_DEV_LIMIT_LOG_LSB+2:`TTC_SYNC_DEV_LIMIT_LOG_LSB]);
  // ****************************************
  // apb slave
  // ****************************************
  // one wait state: ready rises after the first access cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (acc && !pready) begin
        // read mux by address
        if (paddr == `TTC_ADDR_OCF) begin
          prdata <= {opConfig_q[31:3], 1'b0, opConfig_q[1:0]};
        end else if (paddr == `TTC_ADDR_MLM) begin
          prdata <= {4'h0, matrixLimits_q};
        end else if (paddr == `TTC_ADDR_TUR) begin
          prdata <= {elt_q | eltBusy, 1'b0, den_q, numLow_q};
        end else if (paddr == `TTC_ADDR_OCN) begin
          prdata <= {16'h0000, lock_q, 1'b0, opControl_q};
        end else if (paddr == `TTC_ADDR_STS) begin
          prdata <= {wdCnt_q, 22'h000000, watchdogExpired, localTimeRun};
        end else begin
          // unmapped: error answer
          // writes to unmapped offsets are dropped as well
          pslverr <= 1'b1;
        end
      end
    end
  end
  // ****************************************
  // configuration registers
  // ****************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      opConfig_q <= `TTC_OCF_RST;
      matrixLimits_q <= 28'h0000000;
      numLow_q <= `TTC_NCL_RST;
      numLowPend_q <= `TTC_NCL_RST;
      numPend_q <= 1'b0;
      den_q <= `TTC_DEN_RST;
      elt_q <= 1'b0;
      extWaitPrev_q <= 1'b0;
    end else begin
      extWaitPrev_q <= extSyncWait;
      // pending value lands when flag clears
      if (numPend_q && extWaitPrev_q && !extSyncWait) begin
        numLow_q <= numLowPend_q;
        numPend_q <= 1'b0;
      end
      if (wr && !pready) begin
        if (paddr == `TTC_ADDR_OCF && configMode) begin
          opConfig_q <= {5'h00, pwdata[26:3], 1'b0, pwdata[1:0]};
        end else if (paddr == `TTC_ADDR_MLM && configMode) begin
          matrixLimits_q <= {pwdata[27:16], 4'h0, pwdata[11:0]};
        end else if (paddr == `TTC_ADDR_TUR && !eltBusy) begin
          elt_q <= pwdata[`TTC_ELT_BIT];
          // zero denominator ignored; locked while enabled
          if (configMode && !elt_q && pwdata[29:16] != 14'h0000) begin
            den_q <= pwdata[29:16];
          end
          if ((configMode && !elt_q) || (ext_clock_sync_enable && !extSyncWait)) begin
            if (configMode) begin
              numLow_q <= pwdata[15:0];
            end else begin
              numLowPend_q <= pwdata[15:0];
              numPend_q <= 1'b1;
            end
          end
        end
      end
    end
  end
  // ****************************************
  // operation control with lock
  // ****************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      opControl_q <= 14'h0000;
      lock_q <= 1'b0;
      lockPipe_q <= {SYNC_STAGES{1'b0}};
    end else begin
      lockPipe_q <= {lockPipe_q[SYNC_STAGES-2:0], lock_q};
      if (lockPipe_q[SYNC_STAGES-1]) begin
        lock_q <= 1'b0;
      end
      // self-clearing bits 1:0
      opControl_q[1:0] <= 2'h0;
      if (refMsgSeen) begin
        opControl_q[12:10] <= 3'h0;
      end
      if (wr && !pready && paddr == `TTC_ADDR_OCN) begin
        lock_q <= 1'b1;
        // restart the crossing: ones left in the pipe from an earlier
        // write must not release a fresh lock early
        lockPipe_q <= {SYNC_STAGES{1'b0}};
        if (!lock_q) begin
          opControl_q[13] <= pwdata[13];
          opControl_q[9:2] <= pwdata[9:2];
          opControl_q[1:0] <= pwdata[1:0];
          // set beats the reference message clear
          if (!refMsgSeen) begin
            opControl_q[11:10] <= pwdata[11:10];
            // settable only as master in gap mode
            opControl_q[12] <= pwdata[12] && isCurrentMaster && opConfig_q[`TTC_GEN_BIT];
          end else begin
            opControl_q[11:10] <= pwdata[11:10];
            opControl_q[12] <= pwdata[12] && isCurrentMaster && opConfig_q[`TTC_GEN_BIT];
          end
        end
      end
    end
  end
  // ****************************************
  // local time enable crossing
  // ****************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      eltPipe_q <= {SYNC_STAGES{1'b0}};
      eltSync_q <= 1'b0;
    end else begin
      eltPipe_q <= {eltPipe_q[SYNC_STAGES-2:0], elt_q};
      eltSync_q <= eltPipe_q[SYNC_STAGES-1];
    end
  end
  // ****************************************
  // watchdog, events and outputs
  // ****************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      wdPre_q <= 16'h0000;
      wdCnt_q <= 8'h00;
      evtS_q <= 3'h0;
      evtLvl_q <= 1'b0;
      cycleStartPulse <= 1'b0;
      triggerMarkPulse <= 1'b0;
      refStartReq <= 1'b0;
      phaseAlign <= 1'b0;
      watchdogExpired <= 1'b0;
      txCountOverFlag <= 1'b0;
      txCountUnderFlag <= 1'b0;
      globalTimeErrorFlag <= 1'b0;
      actualNumerator <= {`TTC_NCH_VAL, `TTC_NCL_RST};
      unitDenominator <= `TTC_DEN_RST;
      localTimeRun <= 1'b0;
      masterActive <= 1'b0;
      gapMode <= 1'b0;
      operationModeSelect <= `TTC_OM_EVENT;
      txWindowLength <= 5'h01;
      basicCyclesPerMatrix <= 7'h01;
    end else begin
      evtS_q <= {evtS_q[1:0], extEvent};
      if (evtS_q[2] == evtS_q[1]) begin
        evtLvl_q <= evtS_q[1];
      end
      // tick every 256 NTU; zero limit disables
      if (app_watchdog_limit == 8'h00) begin
        // zero limit: watchdog off
        wdPre_q <= 16'h0000;
        wdCnt_q <= 8'h00;
        watchdogExpired <= 1'b0;
      end else if (wdServe) begin
        // serve restarts the count; an expiry in the same cycle still wins
        wdPre_q <= 16'h0000;
        wdCnt_q <= 8'h00;
        watchdogExpired <= wdExpire;
      end else if (ntuTick && localTimeRun) begin
        if (wdPre_q == `TTC_WD_NTU - 1) begin
          wdPre_q <= 16'h0000;
          if (wdCnt_q == app_watchdog_limit) begin
            watchdogExpired <= 1'b1;
          end else begin
            wdCnt_q <= wdCnt_q + 8'h01;
          end
        end else begin
          wdPre_q <= wdPre_q + 16'h0001;
        end
      end
      cycleStartPulse <= (matrixLimits_q[7:6] == 2'h1 && basicStart) ||
                         (matrixLimits_q[7:6] == 2'h2 && matrixStart);
      triggerMarkPulse <= opControl_q[8] && trigActive && inSchedule;
      // mark gap or finish gap starts reference
      refStartReq <= (opControl_q[11] && markIrq) || opControl_q[10];
      // align phase on external event rise
      phaseAlign <= opControl_q[13] && evtRise;
      // compare count at matrix end
      // one-cycle pulses; whoever reads them must latch them
      txCountOverFlag <= matrixStart && txTrigCount > matrixLimits_q[27:16];
      txCountUnderFlag <= matrixStart && txTrigCount < matrixLimits_q[27:16];
      // deviation check in levels 0 and 2
      globalTimeErrorFlag <= opConfig_q[1] && ({3'h0, sync_deviation_limit} < syncDeviation);
      // numerator top bits fixed at 01
      actualNumerator <= {`TTC_NCH_VAL, numLow_q};
      unitDenominator <= den_q;
      // runs while crossed enable is set
      localTimeRun <= eltSync_q;
      masterActive <= opConfig_q[`TTC_TM_BIT];
      gapMode <= opConfig_q[`TTC_GEN_BIT];
      operationModeSelect <= opConfig_q[1:0];
      txWindowLength <= {1'b0, matrixLimits_q[11:8]} + 5'h01;
      basicCyclesPerMatrix <= {1'b0, matrixLimits_q[5:0]} + 7'h01;
    end
  end
endmodule // ttc_timebase_config
`default_nettype wire
